/* logic/gfxdc_top.sv */
// graphics command queue, register file and display pad control
// assumes a classic wishbone master on clk_i, a drawing engine and a display
// timing source whose pixel clock, syncs and data arrive asynchronously
//
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.

module gfxdc_top (
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [gfxdc_pkg::ADR_W-1:0]   wb_adr_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic [31:0]                   wb_dat_i,
	output logic      [31:0]                   wb_dat_o,
	output logic                               wb_ack_o,
	input  wire logic                          cpu_idle_i,
	output logic                               cmd_valid_o,
	output logic      [31:0]                   queued_command_word_o,
	input  wire logic                          cmd_ready_i,
	output logic                               module_running_o,
	output logic      [4:0]                    engine_bits_per_pixel_o,
	output logic      [4:0]                    panel_bits_per_pixel_o,
	input  wire logic                          panel_pixel_clock_i,
	input  wire logic                          hsync_i,
	input  wire logic                          vsync_i,
	input  wire logic                          display_enable_i,
	input  wire logic [gfxdc_pkg::PIX_W-1:0]   pixel_data_i,
	output logic      [gfxdc_pkg::PIX_W-1:0]   data_o,
	output logic      [gfxdc_pkg::PIX_W-1:0]   data_oe_n_o,
	output logic                               panel_enable_signal_o,
	output logic                               panel_enable_signal_oe_n_o,
	output logic                               power_sequencer_pin_o,
	output logic                               power_sequencer_pin_oe_n_o,
	output logic                               vsync_o,
	output logic                               vsync_oe_n_o,
	output logic                               hsync_o,
	output logic                               hsync_oe_n_o
);
	import gfxdc_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic                              ack;
		logic [31:0]                       rdata;
		logic [15:0]                       cmd_low;
		logic [15:0]                       cmd_high;
		logic [15:0]                       con1;
		logic [15:0]                       con2;
		logic [15:0]                       con3;
		logic [15:0]                       mask;
		logic                              wmk_flag;
		logic [QUEUE_DEPTH-1:0][31:0]      queue;
		logic [PTR_W-1:0]                  wr_ptr;
		logic [PTR_W-1:0]                  rd_ptr;
		logic [CNT_W-1:0]                  count;
		logic [SYNC_W-1:0]                 sync1;
		logic [SYNC_W-1:0]                 sync2;
		logic [SYNC_W-1:0]                 sync3;
		logic [PIPE_N-1:0][PIX_W-1:0]      pipe;
		logic [PIX_W-1:0]                  data_out;
		logic                              en_out;
		logic                              vs_out;
		logic                              hs_out;
		logic                              pwr_out;
		logic                              toggle;
		logic [POS_W-1:0]                  col;
		logic [POS_W-1:0]                  line;
	} gfxdc_state_type;

	gfxdc_state_type s;
	gfxdc_state_type next_s;

	// ************************************************************
	// functions
	// ************************************************************
	function automatic logic [15:0] merge16(
		input logic [15:0] old_v,
		input logic [15:0] new_v,
		input logic [1:0]  sel,
		input logic [15:0] wmask
	);
		logic [15:0] lanes;
		lanes = {{8{sel[1]}}, {8{sel[0]}}} & wmask;
		return (old_v & ~lanes) | (new_v & lanes);
	endfunction

	function automatic logic [4:0] depth_bits(input logic [2:0] code);
		logic [4:0] r;
		unique case (code)
			3'h0:    r = 5'h01;
			3'h1:    r = 5'h02;
			3'h2:    r = 5'h04;
			3'h3:    r = 5'h08;
			3'h4:    r = 5'h10;
			default: r = 5'h00;
		endcase
		return r;
	endfunction

	function automatic logic [1:0] stagger_delay(input logic [1:0] mode, input int bit_i);
		logic [1:0] r;
		logic [1:0] b;
		b = bit_i[1:0];
		unique case (mode)
			STAG_NONE:  r = DLY_ZERO;
			STAG_ODD:   r = b[0] ? DLY_HALF : DLY_ZERO;
			STAG_EVEN:  r = b[0] ? DLY_ZERO : DLY_FULL;
			STAG_GROUP: r = b;
		endcase
		return r;
	endfunction

	// ************************************************************
	// decoded fields
	// ************************************************************
	logic [4:0]       wmk;
	logic [2:0]       ptype;
	logic             stn;
	logic             running;
	logic             pop;
	logic             push;
	logic             do_push;
	logic             access;
	logic             wr;
	logic [5:0]       idx;
	logic [15:0]      rd16;
	logic [31:0]      word;
	logic             pclk_rise;
	logic             pclk_fall;
	logic             launch;
	logic             hs_rise;
	logic             vs_rise;
	logic             disp_on;
	logic [PIX_W-1:0] pix;
	logic [PIX_W-1:0] wmask;

	assign wmk   = s.con1[WMK_MSB:WMK_LSB];
	assign ptype = s.con2[TYPE_MSB:TYPE_LSB];
	assign stn   = (ptype == PANEL_MONO) || (ptype == PANEL_COLOR);
	assign running = s.con1[CON1_ON] & ~(s.con1[CON1_IDLE] & cpu_idle_i);
	assign pop = running && (s.count != '0) && cmd_ready_i;
	assign access = wb_cyc_i & wb_stb_i & ~s.ack;
	assign wr = access & wb_we_i;
	assign idx = wb_adr_i[ADR_W-1:2];

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_s = s;
		next_s.ack = access;
		push = 1'b0;
		word = '0;
		rd16 = '0;
		unique case (idx)
			IDX_CMD_LOW:  rd16 = s.cmd_low;
			IDX_CMD_HIGH: rd16 = s.cmd_high;
			IDX_CON1:     rd16 = {s.con1[15:5], s.count};
			IDX_CON2:     rd16 = s.con2;
			IDX_CON3:     rd16 = s.con3;
			IDX_STATUS: begin
				rd16[ST_WMK]   = s.count < wmk;
				rd16[ST_FULL]  = s.count == CNT_FULL;
				rd16[ST_EMPTY] = s.count == '0;
			end
			IDX_FLAGS:    rd16[FL_WMK] = s.wmk_flag;
			IDX_MASK:     rd16 = s.mask;
			default:      rd16 = '0;
		endcase
		if (access) begin
			next_s.rdata = {16'h0000, rd16};
		end
		if (wr) begin
			unique case (idx)
				IDX_CMD_LOW: begin
					next_s.cmd_low = merge16(s.cmd_low, wb_dat_i[15:0], wb_sel_i[1:0], FULL_WMASK);
				end
				IDX_CMD_HIGH: begin
					next_s.cmd_high = merge16(s.cmd_high, wb_dat_i[15:0], wb_sel_i[1:0], FULL_WMASK);
					push = wb_sel_i[1];
				end
				IDX_CON1: next_s.con1 = merge16(s.con1, wb_dat_i[15:0], wb_sel_i[1:0], CON1_WMASK);
				IDX_CON2: next_s.con2 = merge16(s.con2, wb_dat_i[15:0], wb_sel_i[1:0], CON2_WMASK);
				IDX_CON3: next_s.con3 = merge16(s.con3, wb_dat_i[15:0], wb_sel_i[1:0], CON3_WMASK);
				IDX_MASK: next_s.mask = merge16(s.mask, wb_dat_i[15:0], wb_sel_i[1:0], FULL_WMASK);
				IDX_FLAGS: begin
					if (wb_sel_i[0] && wb_dat_i[FL_WMK]) begin
						next_s.wmk_flag = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// command queue
		word = {next_s.cmd_high, s.cmd_low};
		do_push = push && (s.count != CNT_FULL);
		if (do_push) begin
			next_s.queue[s.wr_ptr] = word;
			next_s.wr_ptr = s.wr_ptr + 1'b1;
		end
		if (pop) begin
			next_s.rd_ptr = s.rd_ptr + 1'b1;
		end
		if (do_push && !pop) begin
			next_s.count = s.count + 1'b1;
		end else if (pop && !do_push) begin
			next_s.count = s.count - 1'b1;
		end
		// event set wins over a clear in the same cycle
		if (pop && !do_push && (wmk != '0) && (s.count == wmk)) begin
			next_s.wmk_flag = 1'b1;
		end

		// link side sampling
		next_s.sync1 = {panel_pixel_clock_i, vsync_i, hsync_i, display_enable_i, pixel_data_i};
		next_s.sync2 = s.sync1;
		next_s.sync3 = s.sync2;
		pclk_rise = s.sync2[SY_PCLK] & ~s.sync3[SY_PCLK];
		pclk_fall = ~s.sync2[SY_PCLK] & s.sync3[SY_PCLK];
		hs_rise = s.sync2[SY_HS] & ~s.sync3[SY_HS];
		vs_rise = s.sync2[SY_VS] & ~s.sync3[SY_VS];
		launch = s.con3[C3_CLKPOL] ? pclk_fall : pclk_rise;
		disp_on = running && (ptype == PANEL_TFT || stn);

		if (hs_rise) begin
			next_s.col = '0;
			next_s.line = s.line + 1'b1;
		end else if (launch) begin
			next_s.col = s.col + 1'b1;
		end
		if (vs_rise) begin
			next_s.line = '0;
			next_s.toggle = ~s.toggle;
		end

		unique case (s.con2[TEST_MSB:TEST_LSB])
			TEST_NONE:   pix = s.sync2[PIX_W-1:0];
			TEST_BLACK:  pix = '0;
			TEST_BARS:   pix = {PIX_W{s.col[BAR_BIT]}};
			TEST_BORDER: pix = (s.col == '0 || s.line == '0) ? '1 : '0;
		endcase
		if (!stn) begin
			wmask = '1;
		end else begin
			unique case (s.con2[WIDTH_MSB:WIDTH_LSB])
				WIDTH_4:  wmask = 16'h000f;
				WIDTH_8:  wmask = 16'h00ff;
				WIDTH_16: wmask = 16'hffff;
				default:  wmask = 16'hffff;
			endcase
		end

		if (!disp_on) begin
			next_s.pipe[0] = '0;
		end else if (launch) begin
			next_s.pipe[0] = pix & wmask;
		end
		for (int k = 1; k < PIPE_N; k++) begin
			next_s.pipe[k] = s.pipe[k-1];
		end
		for (int i = 0; i < PIX_W; i++) begin
			next_s.data_out[i] = s.pipe[stagger_delay(s.con2[STAG_MSB:STAG_LSB], i)][i];
		end

		next_s.vs_out = disp_on & (s.sync2[SY_VS] ~^ s.con3[C3_VSPOL]);
		next_s.hs_out = disp_on & (s.sync2[SY_HS] ~^ s.con3[C3_HSPOL]);
		if (!disp_on) begin
			next_s.en_out = 1'b0;
		end else if (!stn) begin
			next_s.en_out = s.sync2[SY_DEN] ~^ s.con3[C3_ENPOL];
		end else if (s.con3[C3_ENPOL]) begin
			next_s.en_out = s.sync2[SY_PCLK] & s.sync2[SY_DEN];
		end else begin
			next_s.en_out = s.toggle;
		end
		next_s.pwr_out = s.con3[C3_POWER];
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign wb_dat_o = s.rdata;
	assign wb_ack_o = s.ack;
	assign cmd_valid_o = running && (s.count != '0);
	assign queued_command_word_o = s.queue[s.rd_ptr];
	assign module_running_o = running;
	assign engine_bits_per_pixel_o = depth_bits(s.con1[EDEPTH_MSB:EDEPTH_LSB]);
	assign panel_bits_per_pixel_o = depth_bits(s.con2[PDEPTH_MSB:PDEPTH_LSB]);
	assign data_o = s.data_out;
	assign data_oe_n_o = ~({PIX_W{s.con3[C3_MASTER]}} & s.mask);
	assign panel_enable_signal_o = s.en_out;
	assign panel_enable_signal_oe_n_o = ~(s.con3[C3_MASTER] & s.con3[C3_ENOE]);
	assign power_sequencer_pin_o = s.pwr_out;
	assign power_sequencer_pin_oe_n_o = ~(s.con3[C3_MASTER] & s.con3[C3_PWROE]);
	assign vsync_o = s.vs_out;
	assign vsync_oe_n_o = ~(s.con3[C3_MASTER] & s.con3[C3_VSOE]);
	assign hsync_o = s.hs_out;
	assign hsync_oe_n_o = ~(s.con3[C3_MASTER] & s.con3[C3_HSOE]);

endmodule

/* logic/gfxdc_pkg.sv */
// constants shared by the graphics command queue and display pad control
// assumes a classic wishbone slave port, 32-bit data, 16-bit registers in low bits
// Functional notes
// - writing command low half stores bits 15..0 only, never pushes
// - full word write to command high half pushes the 32-bit command
// - high byte write to command high pushes; low byte write only stores
// - push into a full sixteen-entry queue is dropped, contents unchanged
// - read-only 5-bit occupancy shows queued commands, 0 to 16
// - nonzero watermark n sets event flag when occupancy falls n to n-1
// - engine pixel depth codes 0..4 mean 1,2,4,8,16 bits per pixel
// - stn width codes give 4, 8 or 16 data lines; tft is always 16
// - stagger delays odd, even or mod-4 bit groups by steps of one clk cycle
// - nonzero test pattern replaces image: black, bars or borders
// - panel type selects off, tft, mono stn or colour stn
// - master pad enable gates every per-signal pad enable
// - with master set, a 16-bit mask enables each data line pad
// - power sequencer pin level follows the power control bit
// - power port enable drives the power pin, else pin is released
// - clock polarity picks the latch edge; data launches on the other
// - enable polarity: tft active level; stn shift clock or frame toggle
// - vsync and hsync polarity bits choose active high or low
// - module enable bit runs the block; halt in idle stops it when idle
// - panel enable port bit connects panel enable pad, under master
// - queued commands start rendering; engine consumes them on its own
// - sync port enable bits drive vsync and hsync pads when set
// - watermark status reads 1 while occupancy is below the watermark

package gfxdc_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam int          ADR_W        = 8;
	localparam logic [5:0]  IDX_CMD_LOW  = 6'h00;
	localparam logic [5:0]  IDX_CMD_HIGH = 6'h01;
	localparam logic [5:0]  IDX_CON1     = 6'h02;
	localparam logic [5:0]  IDX_CON2     = 6'h03;
	localparam logic [5:0]  IDX_CON3     = 6'h04;
	localparam logic [5:0]  IDX_STATUS   = 6'h05;
	localparam logic [5:0]  IDX_FLAGS    = 6'h06;
	localparam logic [5:0]  IDX_MASK     = 6'h07;
	localparam logic [15:0] REG_RESET    = 16'h0000;
	localparam logic [15:0] CON1_WMASK   = 16'hbfe0;
	localparam logic [15:0] CON2_WMASK   = 16'hf3e7;
	localparam logic [15:0] CON3_WMASK   = 16'h03ff;
	localparam logic [15:0] FULL_WMASK   = 16'hffff;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CON1_ON      = 15;
	localparam int CON1_IDLE    = 13;
	localparam int WMK_MSB      = 12;
	localparam int WMK_LSB      = 8;
	localparam int EDEPTH_MSB   = 7;
	localparam int EDEPTH_LSB   = 5;
	localparam int WIDTH_MSB    = 15;
	localparam int WIDTH_LSB    = 14;
	localparam int STAG_MSB     = 13;
	localparam int STAG_LSB     = 12;
	localparam int TEST_MSB     = 9;
	localparam int TEST_LSB     = 8;
	localparam int PDEPTH_MSB   = 7;
	localparam int PDEPTH_LSB   = 5;
	localparam int TYPE_MSB     = 2;
	localparam int TYPE_LSB     = 0;
	localparam int C3_MASTER    = 9;
	localparam int C3_POWER     = 8;
	localparam int C3_CLKPOL    = 7;
	localparam int C3_ENPOL     = 6;
	localparam int C3_VSPOL     = 5;
	localparam int C3_HSPOL     = 4;
	localparam int C3_PWROE     = 3;
	localparam int C3_ENOE      = 2;
	localparam int C3_VSOE      = 1;
	localparam int C3_HSOE      = 0;
	localparam int ST_WMK       = 2;
	localparam int ST_FULL      = 1;
	localparam int ST_EMPTY     = 0;
	localparam int FL_WMK       = 2;

	// ************************************************************
	// codes
	// ************************************************************
	localparam logic [2:0] PANEL_OFF   = 3'h0;
	localparam logic [2:0] PANEL_TFT   = 3'h1;
	localparam logic [2:0] PANEL_MONO  = 3'h2;
	localparam logic [2:0] PANEL_COLOR = 3'h3;
	localparam logic [1:0] TEST_NONE   = 2'h0;
	localparam logic [1:0] TEST_BLACK  = 2'h1;
	localparam logic [1:0] TEST_BARS   = 2'h2;
	localparam logic [1:0] TEST_BORDER = 2'h3;
	localparam logic [1:0] WIDTH_4     = 2'h0;
	localparam logic [1:0] WIDTH_8     = 2'h1;
	localparam logic [1:0] WIDTH_16    = 2'h2;
	localparam logic [1:0] STAG_NONE   = 2'h0;
	localparam logic [1:0] STAG_ODD    = 2'h1;
	localparam logic [1:0] STAG_EVEN   = 2'h2;
	localparam logic [1:0] STAG_GROUP  = 2'h3;

	// ************************************************************
	// queue and link sizes
	// ************************************************************
	localparam int         QUEUE_DEPTH = 16;
	localparam int         PTR_W       = 4;
	localparam int         CNT_W       = 5;
	localparam logic [4:0] CNT_FULL    = 5'h10;
	localparam int         PIX_W       = 16;
	localparam int         SYNC_W      = 20;
	localparam int         SY_DEN      = 16;
	localparam int         SY_HS       = 17;
	localparam int         SY_VS       = 18;
	localparam int         SY_PCLK     = 19;
	localparam int         PIPE_N      = 4;
	localparam int         BAR_BIT     = 3;
	localparam int         POS_W       = 8;
	// delay steps in clk cycles: zero, one and two clk cycles
	localparam logic [1:0] DLY_ZERO    = 2'h0;
	localparam logic [1:0] DLY_HALF    = 2'h1;
	localparam logic [1:0] DLY_FULL    = 2'h2;

endpackage

/* tb/gfxdc_props.sv */
// assertions on the register bus, command queue and pad enables of gfxdc_top
// assumes it sees only the top module's ports and is bound below
module gfxdc_props (
	input wire logic                        clk_i,
	input wire logic                        rst_i,
	input wire logic                        wb_cyc_i,
	input wire logic                        wb_stb_i,
	input wire logic                        wb_we_i,
	input wire logic [gfxdc_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0]                  wb_sel_i,
	input wire logic [31:0]                 wb_dat_i,
	input wire logic [31:0]                 wb_dat_o,
	input wire logic                        wb_ack_o,
	input wire logic                        cmd_valid_o,
	input wire logic                        cmd_ready_i,
	input wire logic                        module_running_o,
	input wire logic [gfxdc_pkg::PIX_W-1:0] data_o,
	input wire logic [gfxdc_pkg::PIX_W-1:0] data_oe_n_o,
	input wire logic                        power_sequencer_pin_o,
	input wire logic                        power_sequencer_pin_oe_n_o,
	input wire logic                        vsync_oe_n_o
);
	import gfxdc_pkg::*;
	// ********************************
	// shadow of queue count and pad registers
	// ********************************
	logic        take, push, pop;
	logic [4:0]  cnt;
	logic [15:0] c3, mask;
	assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign push = take & wb_we_i & (wb_adr_i[7:2] == IDX_CMD_HIGH) & wb_sel_i[1];
	assign pop  = cmd_valid_o & cmd_ready_i;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt  <= 5'h00;
			c3   <= 16'h0000;
			mask <= 16'h0000;
		end else begin
			cnt <= cnt + 5'(push && cnt != CNT_FULL) - 5'(pop);
			if (take && wb_we_i && wb_sel_i[1:0] == 2'h3 && wb_adr_i[7:2] == IDX_CON3)
				c3 <= wb_dat_i[15:0] & CON3_WMASK;
			if (take && wb_we_i && wb_sel_i[1:0] == 2'h3 && wb_adr_i[7:2] == IDX_MASK)
				mask <= wb_dat_i[15:0];
		end
	end
	// ********************************
	// properties
	// ********************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	ack_after_take_a: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack missing or longer than one cycle");
	ack_no_spurious_a: assert property (!take |=> !wb_ack_o)
		else $error("ack without a request");
	unmapped_read_a: assert property (take && !wb_we_i && wb_adr_i[7] |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	occupancy_read_a: assert property (
		take && !wb_we_i && wb_adr_i[7:2] == IDX_CON1 |=> wb_dat_o[4:0] == $past(cnt))
		else $error("occupancy field wrong");
	full_empty_read_a: assert property (
		take && !wb_we_i && wb_adr_i[7:2] == IDX_STATUS |=>
		wb_dat_o[1:0] == {$past(cnt) == CNT_FULL, $past(cnt) == 5'h00})
		else $error("full or empty status wrong");
	valid_tracks_count_a: assert property (cmd_valid_o == (module_running_o && cnt != 5'h00))
		else $error("command valid disagrees with queue count");
	power_pin_a: assert property ($stable(c3) |-> power_sequencer_pin_o == c3[C3_POWER])
		else $error("power pin level wrong");
	power_pad_a: assert property (
		$stable(c3) |-> power_sequencer_pin_oe_n_o == !(c3[C3_MASTER] && c3[C3_PWROE]))
		else $error("power pad enable wrong");
	data_pad_a: assert property (
		$stable(c3) && $stable(mask) |-> data_oe_n_o == ~({16{c3[C3_MASTER]}} & mask))
		else $error("data pad enables wrong");
	vsync_pad_a: assert property (
		$stable(c3) |-> vsync_oe_n_o == !(c3[C3_MASTER] && c3[C3_VSOE]))
		else $error("vsync pad enable wrong");
	dark_stopped_a: assert property (!module_running_o [*8] |-> data_o == '0)
		else $error("data lines active while stopped");
	full_cov: cover property (cnt == CNT_FULL && push);
	pop_cov: cover property (pop ##1 pop);
	pad_cov: cover property (c3[C3_MASTER] && !power_sequencer_pin_oe_n_o);
endmodule

bind gfxdc_top gfxdc_props gfxdc_props_i (.*);

/* tb/gfxdc_panel.sv */
// display timing source and panel glass model
// assumes the bench starts frames with run_i and picks the latch edge
module gfxdc_panel (
	input  wire logic        run_i,
	input  wire logic        rise_latch_i,
	input  wire logic [15:0] pattern_i,
	input  wire logic [15:0] data_i,
	output logic             pclk_o,
	output logic             hsync_o,
	output logic             vsync_o,
	output logic             den_o,
	output logic [15:0]      pix_o,
	output logic [15:0]      latched_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ********************************
	// link clock runs only inside frames
	// ********************************
	int col = 0;
	int line = 0;
	initial begin
		{pclk_o, hsync_o, vsync_o, den_o} = 4'h0;
		pix_o = 16'h0;
		latched_o = 16'h0;
		#1.3;
		forever begin
			#62.5;
			if (run_i) begin
				pclk_o = ~pclk_o;
				if (pclk_o) begin
					col = (col == 19) ? 0 : col + 1;
					if (col == 0) line = (line == 3) ? 0 : line + 1;
					hsync_o = (col < 2);
					vsync_o = (line == 0);
					den_o = (col > 3);
					pix_o = pattern_i;
				end
			end else begin
				{pclk_o, hsync_o, vsync_o, den_o} = 4'h0;
				pix_o = ~pix_o;
			end
		end
	end
	always @(posedge pclk_o) if (rise_latch_i) latched_o <= data_i;
	always @(negedge pclk_o) if (!rise_latch_i) latched_o <= data_i;
endmodule

/* tb/tb.sv */
// self-checking bench for gfxdc_top: registers, command queue, pads, display path
// assumes gfxdc_pkg, the panel model and the bound checker
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import gfxdc_pkg::*;
	logic              clk_i = 1'b0, rst_i = 1'b1, cpu_idle_i = 1'b0, cmd_ready_i = 1'b0;
	logic              wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [ADR_W-1:0]  wb_adr_i = 8'h00;
	logic [3:0]        wb_sel_i = 4'h0;
	logic [31:0]       wb_dat_i = 32'h0, wb_dat_o, queued_command_word_o, c;
	logic              wb_ack_o, cmd_valid_o, module_running_o, drain = 1'b0, run = 1'b0;
	logic              panel_pixel_clock_i, hsync_i, vsync_i, display_enable_i, rise = 1'b0;
	logic [4:0]        engine_bits_per_pixel_o, panel_bits_per_pixel_o;
	logic [PIX_W-1:0]  pixel_data_i, data_o, data_oe_n_o, latched, pattern = 16'h0;
	logic              panel_enable_signal_o, panel_enable_signal_oe_n_o, power_sequencer_pin_o;
	logic              power_sequencer_pin_oe_n_o, vsync_o, vsync_oe_n_o, hsync_o, hsync_oe_n_o;
	logic [31:0]       rdq[$], cmdq[$];
	logic [15:0]       cfg[8] = '{16'h0001, 16'h0002, 16'h5003, 16'ha002, 16'hf002, 16'h0101,
		16'h0000, 16'h0007};
	logic [15:0]       lanes[8] = '{16'hffff, 16'h000f, 16'h00ff, 16'hffff, 16'hffff, 16'h0,
		16'h0, 16'h0};
	int                fail_count = 0, total_checks = 0, cycles = 0;
	always #2.5 clk_i = ~clk_i;
	gfxdc_top gfxdc_top_i (.*);
	gfxdc_panel gfxdc_panel_i (.run_i(run), .rise_latch_i(rise), .pattern_i(pattern),
		.data_i(data_o), .pclk_o(panel_pixel_clock_i), .hsync_o(hsync_i), .vsync_o(vsync_i),
		.den_o(display_enable_i), .pix_o(pixel_data_i), .latched_o(latched));
	// ********************************
	// tasks and monitors
	// ********************************
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		do @(negedge clk_i); while (wb_ack_o !== 1'b1);
		@(posedge clk_i);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rdq.push_back(e);
		bus(1'b0, a, 4'h3, 32'h0);
	endtask
	task automatic send(input logic [31:0] w, input bit keep);
		bus(1'b1, 8'h00, 4'h3, {16'h0, w[15:0]});
		bus(1'b1, 8'h04, 4'h3, {16'h0, w[31:16]});
		if (keep) cmdq.push_back(w);
	endtask
	task automatic empty_queue;
		drain <= 1'b1;
		do @(negedge clk_i); while (cmd_valid_o === 1'b1);
		@(posedge clk_i);
		drain <= 1'b0;
		check("queue left", 32'h0, cmdq.size());
	endtask
	always @(posedge clk_i) cmd_ready_i <= drain & ($urandom_range(2) != 0);
	always @(negedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
			check("read data", rdq.pop_front(), wb_dat_o);
		if (cmd_valid_o === 1'b1 && cmd_ready_i === 1'b1)
			check("command word", cmdq.pop_front(), queued_command_word_o);
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 40000) begin
			fail_count++;
			results();
		end
	end
	// ********************************
	// main sequence
	// ********************************
	initial begin
		void'($urandom(31788));
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 8; i++) rd(8'(i * 4), (i == 5) ? 32'h1 : 32'h0);
		bus(1'b1, 8'h80, 4'hf, 32'hffff);
		rd(8'h80, 32'h0);
		$display("test reset values done");
		bus(1'b1, 8'h00, 4'h3, 32'h1234);
		rd(8'h08, 32'h0);
		bus(1'b1, 8'h04, 4'h1, 32'h0056);
		rd(8'h08, 32'h0);
		bus(1'b1, 8'h04, 4'h2, 32'h7800);
		cmdq.push_back(32'h7856_1234);
		rd(8'h04, 32'h7856);
		for (int i = 0; i < 16; i++) send($urandom, i < 15);
		rd(8'h08, 32'h10);
		rd(8'h14, 32'h2);
		$display("test command entry done");
		bus(1'b1, 8'h08, 4'h3, 32'h8300);
		empty_queue();
		rd(8'h18, 32'h4);
		rd(8'h14, 32'h5);
		bus(1'b1, 8'h18, 4'h1, 32'h4);
		rd(8'h18, 32'h0);
		bus(1'b1, 8'h08, 4'h3, 32'h8000);
		repeat (3) send($urandom, 1'b1);
		empty_queue();
		rd(8'h18, 32'h0);
		$display("test watermark done");
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, 8'h08, 4'h3, 32'h8000 | (k[1] << 13));
			cpu_idle_i <= k[0];
			@(negedge clk_i);
			check("running", !(k[1] && k[0]), module_running_o);
		end
		cpu_idle_i <= 1'b0;
		for (int d = 0; d < 8; d++) begin
			bus(1'b1, 8'h08, 4'h3, 32'h801f | (d << 5));
			bus(1'b1, 8'h0c, 4'h3, 32'h0001 | (d << 5));
			rd(8'h08, 32'h8000 | (d << 5));
			check("depths", (d < 5) ? {2{5'(1 << d)}} : 10'h0,
				{engine_bits_per_pixel_o, panel_bits_per_pixel_o});
		end
		$display("test control fields done");
		for (int i = 0; i < 8; i++) begin
			c = $urandom;
			c[9] = i[0];
			bus(1'b1, 8'h1c, 4'h3, {16'h0, c[31:16]});
			bus(1'b1, 8'h10, 4'h3, {22'h0, c[9:0]});
			repeat (2) @(negedge clk_i);
			check("pads", {~({16{c[9]}} & c[31:16]), ~(c[9] & c[2]), ~(c[9] & c[3]), c[8]},
				{data_oe_n_o, panel_enable_signal_oe_n_o, power_sequencer_pin_oe_n_o,
				power_sequencer_pin_o});
			check("sync pads", {~(c[9] & c[1]), ~(c[9] & c[0])},
				{vsync_oe_n_o, hsync_oe_n_o});
		end
		$display("test pads done");
		bus(1'b1, 8'h1c, 4'h3, 32'hffff);
		run <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			pattern <= 16'($urandom);
			rise <= i[0];
			bus(1'b1, 8'h10, 4'h3, 32'h037f | (i[0] << 7));
			bus(1'b1, 8'h0c, 4'h3, {16'h0, cfg[i]});
			repeat (1200) @(negedge clk_i);
			check("panel data", pattern & lanes[i], latched);
		end
		run <= 1'b0;
		bus(1'b1, 8'h0c, 4'h3, 32'h0001);
		for (int p = 0; p < 8; p++) begin
			bus(1'b1, 8'h10, 4'h3, 32'h030f | (p << 4));
			repeat (8) @(negedge clk_i);
			check("idle levels", {29'h0, ~p[2:0]},
				{panel_enable_signal_o, vsync_o, hsync_o});
		end
		$display("test display link done");
		results();
	end
endmodule
